/* rtl/drcb_map.svh */
// register offsets, field positions and reset values of the code buffer block
`ifndef DRCB_MAP_SVH
`define DRCB_MAP_SVH

// byte offsets on the register bus, one word per register
`define DRCB_OFS_CTRL1 8'h00
`define DRCB_OFS_HIGH1 8'h04
`define DRCB_OFS_LOW1 8'h08
`define DRCB_OFS_CTRL2 8'h0C
`define DRCB_OFS_HIGH2 8'h10
`define DRCB_OFS_LOW2 8'h14
`define DRCB_OFS_LOAD 8'h18

// instance control fields
`define DRCB_CTRL_EN 7
`define DRCB_CTRL_JUST 6
`define DRCB_CTRL_OE 5
`define DRCB_CTRL_PSS_HI 3
`define DRCB_CTRL_PSS_LO 2
`define DRCB_CTRL_NSS 0
`define DRCB_CTRL_WMASK 8'hED

// low holding bits kept when left justified
`define DRCB_LOW_LEFT_MASK 8'hC0
// high holding bits kept when right justified
`define DRCB_HIGH_RIGHT_MASK 8'h03

// load register fields
`define DRCB_LOAD_INST1 0
`define DRCB_LOAD_INST2 1

// reset values
`define DRCB_RST_BYTE 8'h00
`define DRCB_RST_CODE 10'h000

`endif

/* rtl/drcb_pkg.sv */
// types shared by the code buffer block
package drcb_pkg;

    // per instance signals toward the analog converter
    typedef struct packed {
        logic enable;
        logic pin_output_enable;
        logic [1:0] positive_source_select;
        logic negative_source_select;
        logic [9:0] code;
    } drcb_dac_out_t;

    // one decoded register select
    typedef enum {
        DRCB_SEL_NONE,
        DRCB_SEL_CTRL,
        DRCB_SEL_HIGH,
        DRCB_SEL_LOW,
        DRCB_SEL_LOAD
    } drcb_sel_t;

endpackage

/* rtl/drcb_top.sv */
// double buffered reference code registers for up to two converter instances
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`include "drcb_map.svh"
`timescale 1ns/1ps
`default_nettype none

module drcb_top #(
    parameter int NUM_INST = 2,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,

    // avalon-mm slave
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    output var logic [31:0] avs_readdata_o,
    output var logic avs_waitrequest_o,

    // converter side, index 0 is instance one
    output var drcb_pkg::drcb_dac_out_t [1:0] dac_o
);

    // holding registers, control and active codes
    logic [7:0] ctrl_r [2];
    logic [7:0] high_r [2];
    logic [7:0] low_r [2];
    logic [9:0] code_r [2];
    logic [1:0] load_r;

    // bus handshake state
    logic wait_r;
    logic wait_nxt;
    logic ready;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0] load_nxt;

    // masked register views per instance
    logic [7:0] ctrl_rd [2];
    logic [7:0] high_rd [2];
    logic [7:0] low_rd [2];

    // decoded access
    drcb_pkg::drcb_sel_t sel;
    logic sel_inst;
    logic mapped;
    logic wr_take;
    logic rd_take;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;

    // left justified when set
    function automatic logic is_left(input logic [7:0] ctrl);
        is_left = ctrl[`DRCB_CTRL_JUST];
    endfunction

    // ten bit code assembled from a holding pair
    function automatic logic [9:0] pair_code(
        input logic left,
        input logic [7:0] high,
        input logic [7:0] low
    );
        if (left) begin
            pair_code = {high, low[7:6]};
        end else begin
            pair_code = {high[1:0], low};
        end
    endfunction

    // high holding as seen on a read
    function automatic logic [7:0] high_view(input logic left, input logic [7:0] high);
        if (left) begin
            high_view = high;
        end else begin
            high_view = high & `DRCB_HIGH_RIGHT_MASK;
        end
    endfunction

    // low holding as seen on a read
    function automatic logic [7:0] low_view(input logic left, input logic [7:0] low);
        if (left) begin
            low_view = low & `DRCB_LOW_LEFT_MASK;
        end else begin
            low_view = low;
        end
    endfunction

    // address decode
    always_comb begin
        sel = drcb_pkg::DRCB_SEL_NONE;
        sel_inst = 1'b0;
        case (avs_address_i)
            `DRCB_OFS_CTRL1: begin
                sel = drcb_pkg::DRCB_SEL_CTRL;
            end
            `DRCB_OFS_HIGH1: begin
                sel = drcb_pkg::DRCB_SEL_HIGH;
            end
            `DRCB_OFS_LOW1: begin
                sel = drcb_pkg::DRCB_SEL_LOW;
            end
            `DRCB_OFS_CTRL2: begin
                sel = drcb_pkg::DRCB_SEL_CTRL;
                sel_inst = 1'b1;
            end
            `DRCB_OFS_HIGH2: begin
                sel = drcb_pkg::DRCB_SEL_HIGH;
                sel_inst = 1'b1;
            end
            `DRCB_OFS_LOW2: begin
                sel = drcb_pkg::DRCB_SEL_LOW;
                sel_inst = 1'b1;
            end
            `DRCB_OFS_LOAD: begin
                sel = drcb_pkg::DRCB_SEL_LOAD;
            end
            default: begin
                sel = drcb_pkg::DRCB_SEL_NONE;
            end
        endcase
    end

    // second instance registers vanish on a one instance build
    assign mapped = (sel != drcb_pkg::DRCB_SEL_NONE) && (!sel_inst || NUM_INST > 1);

    // access completes on the edge where waitrequest is seen low
    assign ready = !wait_r;
    // lane zero carries the register; without it a write is answered and dropped
    assign wr_take = avs_write_i && ready && mapped && avs_byteenable_i[0];
    // read data captured in the wait cycle so it stands in the ready cycle
    assign rd_take = avs_read_i && wait_r;
    assign wbyte = avs_writedata_i[7:0];

    // read multiplexer
    always_comb begin
        rd_byte = `DRCB_RST_BYTE;
        if (mapped) begin
            case (sel)
                drcb_pkg::DRCB_SEL_CTRL: begin
                    rd_byte = ctrl_rd[sel_inst];
                end
                drcb_pkg::DRCB_SEL_HIGH: begin
                    rd_byte = high_rd[sel_inst];
                end
                drcb_pkg::DRCB_SEL_LOW: begin
                    rd_byte = low_rd[sel_inst];
                end
                drcb_pkg::DRCB_SEL_LOAD: begin
                    rd_byte = {6'h00, load_r};
                end
                default: begin
                    rd_byte = `DRCB_RST_BYTE;
                end
            endcase
        end
    end

    // one wait cycle, then a single ready cycle per request
    always_comb begin
        wait_nxt = 1'b1;
        if ((avs_read_i || avs_write_i) && wait_r) begin
            wait_nxt = 1'b0;
        end
    end

    // waitrequest register, high while idle
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= wait_nxt;
        end
    end

    // read data registered with the ready cycle; unmapped reads give zero
    always_comb begin
        rdata_nxt = rdata_r;
        if (rd_take) begin
            rdata_nxt = {24'h00_0000, rd_byte};
        end
    end

    // read data register, holds until the next read
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // load bits: set by software, cleared after the one transfer cycle
    always_comb begin
        load_nxt = 2'h0;
        if (wr_take && sel == drcb_pkg::DRCB_SEL_LOAD) begin
            load_nxt[`DRCB_LOAD_INST1] = wbyte[`DRCB_LOAD_INST1];
            load_nxt[`DRCB_LOAD_INST2] = wbyte[`DRCB_LOAD_INST2] && NUM_INST > 1;
        end
    end

    // load bit register
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            load_r <= 2'h0;
        end else begin
            load_r <= load_nxt;
        end
    end

    // per instance registers and active code; a one instance build never writes the second
    for (genvar gi = 0; gi < 2; gi++) begin : g_inst
        logic here;
        logic wr_ctrl;
        logic wr_high;
        logic wr_low;
        logic left_just;
        logic [9:0] pair_val;
        assign here = wr_take && (sel_inst == 1'(gi)) && (gi < NUM_INST);
        assign wr_ctrl = here && sel == drcb_pkg::DRCB_SEL_CTRL;
        assign wr_high = here && sel == drcb_pkg::DRCB_SEL_HIGH;
        assign wr_low = here && sel == drcb_pkg::DRCB_SEL_LOW;
        assign left_just = is_left(ctrl_r[gi]);

        // views seen by a read; the stored holding bytes stay whole
        assign ctrl_rd[gi] = ctrl_r[gi] & `DRCB_CTRL_WMASK;
        assign high_rd[gi] = high_view(left_just, high_r[gi]);
        assign low_rd[gi] = low_view(left_just, low_r[gi]);

        // justify at load time decides how the pair forms the code
        assign pair_val = pair_code(left_just, high_r[gi], low_r[gi]);

        // control register, unimplemented bits never stored
        always_ff @(posedge sys_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                ctrl_r[gi] <= `DRCB_RST_BYTE;
            end else if (wr_ctrl) begin
                ctrl_r[gi] <= wbyte & `DRCB_CTRL_WMASK;
            end
        end

        // high holding byte
        always_ff @(posedge sys_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                high_r[gi] <= `DRCB_RST_BYTE;
            end else if (wr_high) begin
                high_r[gi] <= wbyte;
            end
        end

        // low holding byte
        always_ff @(posedge sys_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                low_r[gi] <= `DRCB_RST_BYTE;
            end else if (wr_low) begin
                low_r[gi] <= wbyte;
            end
        end

        // active buffer moves all ten bits at once on its load bit
        always_ff @(posedge sys_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                code_r[gi] <= `DRCB_RST_CODE;
            end else if (load_r[gi]) begin
                code_r[gi] <= pair_val;
            end
        end
    end

    // converter drive straight from the registers
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            dac_o[i].enable = ctrl_r[i][`DRCB_CTRL_EN];
            dac_o[i].pin_output_enable = ctrl_r[i][`DRCB_CTRL_OE];
            dac_o[i].positive_source_select = ctrl_r[i][`DRCB_CTRL_PSS_HI:`DRCB_CTRL_PSS_LO];
            dac_o[i].negative_source_select = ctrl_r[i][`DRCB_CTRL_NSS];
            dac_o[i].code = code_r[i];
        end
    end

    assign avs_waitrequest_o = wait_r;
    assign avs_readdata_o = rdata_r;

endmodule

`default_nettype wire

/* dv/drcb_props.sv */
// port assertions and covers for the code buffer block
`timescale 1ns/1ps
`default_nettype none
`include "drcb_map.svh"
module drcb_props #(
    parameter int NUM_INST = 2,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // register bus
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // converter side
    input wire drcb_pkg::drcb_dac_out_t [1:0] dac_o
);
    logic wr_done;
    logic rd_done;
    logic ld_wr;
    logic ld1_wr;
    logic ld2_wr;
    assign wr_done = avs_write_i && !avs_waitrequest_o;
    assign rd_done = avs_read_i && !avs_waitrequest_o;
    assign ld_wr = wr_done && avs_address_i == `DRCB_OFS_LOAD && avs_byteenable_i[0];
    assign ld1_wr = ld_wr && avs_writedata_i[`DRCB_LOAD_INST1];
    assign ld2_wr = ld_wr && avs_writedata_i[`DRCB_LOAD_INST2];
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    a_wait_one_cycle:
        assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("waitrequest not low one cycle after request");
    a_wait_pulse_short:
        assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    a_read_upper_zero:
        assert property (rd_done |-> avs_readdata_o[31:8] == 24'h0)
        else $error("read data upper bytes not zero");
    a_ctrl_gaps_zero:
        assert property (rd_done && (avs_address_i == `DRCB_OFS_CTRL1
            || avs_address_i == `DRCB_OFS_CTRL2) |-> !avs_readdata_o[4] && !avs_readdata_o[1])
        else $error("control gap bits read nonzero");
    a_load_gaps_zero:
        assert property (rd_done && avs_address_i == `DRCB_OFS_LOAD |-> avs_readdata_o[7:2] == 6'h0)
        else $error("load upper bits read nonzero");
    a_code1_on_load:
        assert property ($changed(dac_o[0].code) |-> $past(ld1_wr, 2))
        else $error("code one changed without load");
    a_code2_on_load:
        assert property ($changed(dac_o[1].code) |-> $past(ld2_wr, 2))
        else $error("code two changed without load");
    a_reset_clears_all:
        assert property (disable iff (1'b0) !resetn_i |-> dac_o == '0 && avs_waitrequest_o)
        else $error("outputs not cleared in reset");
    c_both_load: cover property (ld_wr && avs_writedata_i[1:0] == 2'h3);
    c_code2_move: cover property ($changed(dac_o[1].code));
    c_low_read: cover property (rd_done && avs_address_i == `DRCB_OFS_LOW1);
endmodule
bind drcb_top drcb_props #(.NUM_INST(NUM_INST), .ADDR_W(ADDR_W)) i_props (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .dac_o(dac_o));
`default_nettype wire

/* dv/tb.sv */
// register level testbench of the code buffer block
`timescale 1ns/1ps
`default_nettype none
`include "drcb_map.svh"
module tb;
    logic clk = 1'b0;
    logic rstn = 1'b1;
    logic [3:0] be = 4'hF;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic wait_o;
    drcb_pkg::drcb_dac_out_t [1:0] dac;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    drcb_top #(.NUM_INST(2), .ADDR_W(8)) i_dut (.sys_clk_i(clk), .resetn_i(rstn),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(be),
        .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o), .dac_o(dac));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic final_report;
        $display("errors %0d checks %0d", err_total, checked);
        if (err_total == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // one bus cycle, request held until waitrequest seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [31:0] q);
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= {24'h0, d};
        do begin
            @(posedge clk);
        end while (wait_o !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd8(input logic [7:0] a, input logic [31:0] e, input string n);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(n, e, q);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            final_report();
        end
    end
    initial begin
        rstn <= 1'b0;
        repeat (16) @(posedge clk);
        chk("dac in reset", 32'h0, {2'h0, dac});
        rstn <= 1'b1;
        for (int a = 0; a <= 24; a += 4) rd8(8'(a), 32'h0, "reset value");
        wr8(`DRCB_OFS_CTRL1, 8'hFF);
        rd8(`DRCB_OFS_CTRL1, 32'hED, "ctrl1");
        chk("dac1 fields", 32'h1F, {27'h0, dac[0].enable, dac[0].pin_output_enable,
            dac[0].positive_source_select, dac[0].negative_source_select});
        wr8(`DRCB_OFS_HIGH1, 8'hA5);
        wr8(`DRCB_OFS_LOW1, 8'hFF);
        rd8(`DRCB_OFS_LOW1, 32'hC0, "low1 left");
        rd8(`DRCB_OFS_HIGH1, 32'hA5, "high1 left");
        chk("code1 held", 32'h0, {22'h0, dac[0].code});
        wr8(`DRCB_OFS_LOAD, 8'hFD);
        @(posedge clk);
        #1;
        chk("code1", 32'h297, {22'h0, dac[0].code});
        chk("code2", 32'h0, {22'h0, dac[1].code});
        rd8(`DRCB_OFS_LOAD, 32'h0, "load");
        wr8(`DRCB_OFS_CTRL1, 8'h00);
        rd8(`DRCB_OFS_LOW1, 32'hFF, "low1 right");
        rd8(`DRCB_OFS_HIGH1, 32'h01, "high1 right");
        wr8(`DRCB_OFS_CTRL2, 8'hC1);
        rd8(`DRCB_OFS_CTRL2, 32'hC1, "ctrl2");
        chk("dac2 fields", 32'h11, {27'h0, dac[1].enable, dac[1].pin_output_enable,
            dac[1].positive_source_select, dac[1].negative_source_select});
        wr8(`DRCB_OFS_HIGH2, 8'h3C);
        wr8(`DRCB_OFS_LOW2, 8'h40);
        wr8(`DRCB_OFS_HIGH1, 8'h02);
        wr8(`DRCB_OFS_LOW1, 8'h34);
        wr8(`DRCB_OFS_LOAD, 8'h03);
        @(posedge clk);
        #1;
        chk("code1 both", 32'h234, {22'h0, dac[0].code});
        chk("code2 both", 32'h0F1, {22'h0, dac[1].code});
        wr8(`DRCB_OFS_LOAD, 8'h00);
        wr8(`DRCB_OFS_HIGH1, 8'hFF);
        repeat (2) @(posedge clk);
        chk("code1 kept", 32'h234, {22'h0, dac[0].code});
        be <= 4'hE;
        wr8(`DRCB_OFS_HIGH1, 8'h00);
        be <= 4'hF;
        rd8(`DRCB_OFS_HIGH1, 32'h03, "high1 lane off");
        wr8(8'h1C, 8'hFF);
        rd8(8'h1C, 32'h0, "unmapped");
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        #1;
        chk("dac reset", 32'h0, {2'h0, dac});
        @(posedge clk);
        rstn <= 1'b1;
        rd8(`DRCB_OFS_HIGH1, 32'h0, "high1 reset");
        final_report();
    end
endmodule
`default_nettype wire
